// *** src/uart_frame_len_int_status.sv ***
// frame length register, status flags and apb slave of the serial unit
`timescale 1ns/1ps
module uart_frame_len_int_status (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// apb slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [31:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// serial line and oversampling tick from the baud generator
	input  wire logic        rxd_i,
	input  wire logic        baud16_tick_i,
	// modem status inputs
	input  wire logic        carrier_i,
	input  wire logic        data_set_ready_i,
	input  wire logic        clear_to_send_i,
	// dma handshake
	input  wire logic        rx_dma_ack_i,
	input  wire logic        rx_dma_page_i,
	input  wire logic        tx_dma_page_i,
	output logic             rx_dma_req_o,
	output logic             rx_dma_stop_o,
	output logic             tx_dma_stop_o,
	output logic      [8:0]  rx_data_o,
	// frame settings for the transmit shifter
	output logic      [3:0]  tx_frame_bits_o,
	output logic             two_stop_o,
	// unit interrupt
	output logic             irq_o
);

	rx_frame_if rf ();

	// registers
	logic [15:0] frame_length_config;
	logic [15:0] serial_interrupt_status;
	logic [15:0] serial_control_reg;
	logic        carrier_q;
	logic        dsr_q;
	logic        cts_q;
	logic        rx_valid;
	logic [15:0] next_status;
	logic [15:0] set_vec;

	// fields
	wire [3:0]  rx_frame_length   = frame_length_config[uart_flags_pkg::RX_LEN_LSB +: 4];
	wire [3:0]  tx_frame_length   = frame_length_config[uart_flags_pkg::TX_LEN_LSB +: 4];
	wire        stop_length_sel   = frame_length_config[uart_flags_pkg::STOP_POS];
	wire        rx_enable         = serial_control_reg[uart_flags_pkg::RXEN_POS];
	wire        modem_detect_enable = serial_control_reg[uart_flags_pkg::MDE_POS];

	// apb decode
	wire        hit_len   = paddr_i == uart_flags_pkg::byte_addr(uart_flags_pkg::LEN_IDX);
	wire        hit_stat  = paddr_i == uart_flags_pkg::byte_addr(uart_flags_pkg::STAT_IDX);
	wire        hit_ctrl  = paddr_i == uart_flags_pkg::byte_addr(uart_flags_pkg::CTRL_IDX);
	wire        hit_any   = hit_len || hit_stat || hit_ctrl;
	// one wait state so that pready and prdata both leave flip-flops
	wire        access    = psel_i && penable_i && !pready_o;
	wire        done      = psel_i && penable_i && pready_o;
	wire        wr_len    = done && pwrite_i && hit_len;
	wire        wr_stat   = done && pwrite_i && hit_stat;
	wire        wr_ctrl   = done && pwrite_i && hit_ctrl;
	wire [15:0] clr_vec   = wr_stat ? (pwdata_i[15:0] & uart_flags_pkg::STAT_MASK) : 16'h0000;
	// unused bits never store, so they always read zero
	wire [15:0] rd_mux    = hit_len  ? (frame_length_config & uart_flags_pkg::LEN_MASK) :
				hit_stat ? (serial_interrupt_status & uart_flags_pkg::STAT_MASK) :
				hit_ctrl ? (serial_control_reg & uart_flags_pkg::CTRL_MASK) :
				16'h0000;

	// modem change events
	wire        carrier_chg = modem_detect_enable && (carrier_i != carrier_q);
	wire        dsr_chg     = modem_detect_enable && (data_set_ready_i != dsr_q);
	wire        cts_chg     = modem_detect_enable && (clear_to_send_i != cts_q);

	// receive holding and dma events
	wire        rx_lost   = rf.char_done && rx_valid && !rx_dma_ack_i;
	wire        rx_take   = rf.char_done && !rx_lost;
	wire        rx_p1     = rx_dma_page_i;
	wire        rx_p2     = rx_dma_page_i && serial_interrupt_status[uart_flags_pkg::RXP1_POS];
	wire        tx_p1     = tx_dma_page_i;
	wire        tx_p2     = tx_dma_page_i && serial_interrupt_status[uart_flags_pkg::TXP1_POS];

	// receive timer hookup
	assign rf.enable   = rx_enable;
	assign rf.break_en = rx_enable && modem_detect_enable;
	assign rf.rxd      = rxd_i;
	assign rf.tick     = baud16_tick_i;
	assign rf.rx_bits  = uart_flags_pkg::rx_len_bits(rx_frame_length);
	assign rf.two_stop = stop_length_sel;

	rx_frame_timer u_timer (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.rf        (rf)
	);

	// event placement in the status word
	always_comb begin
		set_vec = 16'h0000;
		set_vec[uart_flags_pkg::BRK_POS]  = rf.break_det;
		set_vec[uart_flags_pkg::FRAMING_POS] = rf.frame_err;
		set_vec[uart_flags_pkg::DCD_POS]  = carrier_chg;
		set_vec[uart_flags_pkg::DSR_POS]  = dsr_chg;
		set_vec[uart_flags_pkg::CTS_POS]  = cts_chg;
		set_vec[uart_flags_pkg::LOST_POS] = rx_lost;
		set_vec[uart_flags_pkg::DONE_POS] = rx_dma_ack_i && rx_valid;
		set_vec[uart_flags_pkg::RXP2_POS] = rx_p2;
		set_vec[uart_flags_pkg::RXP1_POS] = rx_p1;
		set_vec[uart_flags_pkg::TXP2_POS] = tx_p2;
		set_vec[uart_flags_pkg::TXP1_POS] = tx_p1;
	end

	// a new event beats a clear in the same cycle
	assign next_status = ((serial_interrupt_status & ~clr_vec) | set_vec)
				& uart_flags_pkg::STAT_MASK;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			serial_interrupt_status <= uart_flags_pkg::STAT_RESET;
		else
			serial_interrupt_status <= next_status;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_length_config <= uart_flags_pkg::LEN_RESET;
			serial_control_reg  <= uart_flags_pkg::CTRL_RESET;
		end else begin
			if (wr_len)
				frame_length_config <= pwdata_i[15:0] & uart_flags_pkg::LEN_MASK;
			if (wr_ctrl)
				serial_control_reg <= pwdata_i[15:0] & uart_flags_pkg::CTRL_MASK;
		end
	end

	// inputs are synchronous already, one stage is enough for edge detection
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			carrier_q <= 1'b0;
			dsr_q     <= 1'b0;
			cts_q     <= 1'b0;
		end else begin
			carrier_q <= carrier_i;
			dsr_q     <= data_set_ready_i;
			cts_q     <= clear_to_send_i;
		end
	end

	// holding register keeps the older character when a new one finds it full
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_valid  <= 1'b0;
			rx_data_o <= 9'h000;
		end else begin
			if (rx_take) begin
				rx_valid  <= 1'b1;
				rx_data_o <= rf.char_data;
			end else if (rx_dma_ack_i) begin
				rx_valid  <= 1'b0;
			end
		end
	end

	// dma request and stop; requests halt while receive page two is flagged
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_dma_req_o  <= 1'b0;
			rx_dma_stop_o <= 1'b0;
			tx_dma_stop_o <= 1'b0;
		end else begin
			rx_dma_stop_o <= next_status[uart_flags_pkg::RXP2_POS];
			tx_dma_stop_o <= next_status[uart_flags_pkg::TXP2_POS];
			rx_dma_req_o  <= (rx_take || (rx_valid && !rx_dma_ack_i))
				&& !next_status[uart_flags_pkg::RXP2_POS];
		end
	end

	// settings handed to the transmit shifter, and the unit interrupt
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_frame_bits_o <= 4'h0;
			two_stop_o      <= 1'b0;
			irq_o           <= 1'b0;
		end else begin
			tx_frame_bits_o <= uart_flags_pkg::tx_len_bits(tx_frame_length);
			two_stop_o      <= stop_length_sel;
			irq_o           <= |next_status;
		end
	end

	// apb answer
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h00000000;
		end else begin
			pready_o  <= access;
			pslverr_o <= access && !hit_any;
			if (access)
				prdata_o <= {16'h0000, rd_mux};
		end
	end

endmodule

// *** src/uart_flags_pkg.sv ***
// constants, types and helpers for the frame length and status block
package uart_flags_pkg;

	// register indices; byte address is four times the index
	localparam logic [31:0] LEN_IDX   = 32'h0B000146;
	localparam logic [31:0] STAT_IDX  = 32'h0B000148;
	localparam logic [31:0] CTRL_IDX  = 32'h0B000150;

	// frame_length_config fields
	localparam int          STOP_POS  = 8;
	localparam int          RX_LEN_LSB = 4;
	localparam int          TX_LEN_LSB = 0;
	localparam logic [15:0] LEN_MASK  = 16'h01FF;
	localparam logic [15:0] LEN_RESET = 16'h0000;

	// serial_interrupt_status fields
	localparam int          BRK_POS   = 10;
	localparam int          FRAMING_POS = 9;
	localparam int          DCD_POS   = 8;
	localparam int          DSR_POS   = 7;
	localparam int          CTS_POS   = 6;
	localparam int          LOST_POS  = 5;
	localparam int          DONE_POS  = 4;
	localparam int          RXP2_POS  = 3;
	localparam int          RXP1_POS  = 2;
	localparam int          TXP2_POS  = 1;
	localparam int          TXP1_POS  = 0;
	localparam logic [15:0] STAT_MASK = 16'h07FF;
	localparam logic [15:0] STAT_RESET = 16'h0000;

	// control register fields
	localparam int          RXEN_POS  = 2;
	localparam int          MDE_POS   = 6;
	localparam logic [15:0] CTRL_MASK = 16'h0044;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// oversampling of the baud tick
	localparam logic [3:0]  MID_TICK  = 4'h7;
	localparam logic [3:0]  LAST_TICK = 4'hF;
	localparam logic [3:0]  MAX_DBITS = 4'h9;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_START = 2'b01,
		ST_DATA  = 2'b11,
		ST_STOP  = 2'b10
	} rx_state_t;

	function automatic logic [31:0] byte_addr(input logic [31:0] idx);
		byte_addr = {idx[29:0], 2'b00};
	endfunction

	// reserved codes fall back to the shortest legal frame
	function automatic logic [3:0] rx_len_bits(input logic [3:0] code);
		rx_len_bits = (code == 4'hA || code == 4'h9 || code == 4'h8) ? code : 4'h8;
	endfunction

	function automatic logic [3:0] tx_len_bits(input logic [3:0] code);
		tx_len_bits = (code >= 4'h9 && code <= 4'hC) ? code : 4'h9;
	endfunction

endpackage

// *** src/rx_frame_if.sv ***
// signals between the status block and its receive frame timer
`timescale 1ns/1ps
interface rx_frame_if;
	logic       enable;
	logic       break_en;
	logic       rxd;
	logic       tick;
	logic [3:0] rx_bits;
	logic       two_stop;
	logic       char_done;
	logic [8:0] char_data;
	logic       frame_err;
	logic       break_det;

	modport timer (
		input  enable, break_en, rxd, tick, rx_bits, two_stop,
		output char_done, char_data, frame_err, break_det
	);
	modport ctrl (
		output enable, break_en, rxd, tick, rx_bits, two_stop,
		input  char_done, char_data, frame_err, break_det
	);
endinterface

// *** src/rx_frame_timer.sv ***
// receive frame timer: start, data, stop sampling and break watch
`timescale 1ns/1ps
module rx_frame_timer (
	// clock and reset
	input  wire logic  clk_i,
	input  wire logic  sys_rst_i,
	// link to the status block
	rx_frame_if.timer  rf
);

	uart_flags_pkg::rx_state_t state;
	logic [3:0] tick_cnt;
	logic [3:0] bit_cnt;
	logic       stop_cnt;
	logic [8:0] shift;
	logic [8:0] brk_cnt;
	logic       brk_seen;

	wire        at_mid     = rf.tick && tick_cnt == uart_flags_pkg::MID_TICK;
	wire        at_bit     = rf.tick && tick_cnt == uart_flags_pkg::LAST_TICK;
	// bits after the start bit: data plus parity
	wire [3:0]  last_bit   = rf.rx_bits - 4'h2;
	wire [3:0]  align      = uart_flags_pkg::MAX_DBITS - (rf.rx_bits - 4'h1);
	wire        stop_zero  = at_bit && !rf.rxd;
	wire        stop_last  = stop_cnt == rf.two_stop;
	// whole character in ticks: receive length plus stop bits, times sixteen
	wire [8:0]  brk_limit  = {1'b0, (rf.rx_bits + {3'b000, rf.two_stop} + 4'h1), 4'h0};

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state    <= uart_flags_pkg::ST_IDLE;
			tick_cnt <= 4'h0;
			bit_cnt  <= 4'h0;
			stop_cnt <= 1'b0;
			shift    <= 9'h000;
		end else if (!rf.enable) begin
			state    <= uart_flags_pkg::ST_IDLE;
		end else if (rf.tick) begin
			tick_cnt <= tick_cnt + 4'h1;
			unique case (state)
				uart_flags_pkg::ST_IDLE: begin
					tick_cnt <= 4'h0;
					if (!rf.rxd)
						state <= uart_flags_pkg::ST_START;
				end
				uart_flags_pkg::ST_START: begin
					if (at_mid) begin
						tick_cnt <= 4'h0;
						bit_cnt  <= 4'h0;
						state    <= rf.rxd ? uart_flags_pkg::ST_IDLE : uart_flags_pkg::ST_DATA;
					end
				end
				uart_flags_pkg::ST_DATA: begin
					if (at_bit) begin
						shift   <= {rf.rxd, shift[8:1]};
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == last_bit) begin
							stop_cnt <= 1'b0;
							state    <= uart_flags_pkg::ST_STOP;
						end
					end
				end
				uart_flags_pkg::ST_STOP: begin
					if (stop_zero) begin
						bit_cnt <= 4'h0;
						state   <= uart_flags_pkg::ST_DATA;
					end else if (at_bit) begin
						stop_cnt <= 1'b1;
						if (stop_last)
							state <= uart_flags_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// one pulse per character, and a framing pulse with it when a stop reads zero
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rf.char_done <= 1'b0;
			rf.frame_err <= 1'b0;
			rf.char_data <= 9'h000;
		end else begin
			rf.char_done <= rf.enable && state == uart_flags_pkg::ST_STOP
				&& at_bit && (stop_zero || stop_last);
			rf.frame_err <= rf.enable && state == uart_flags_pkg::ST_STOP && stop_zero;
			if (state == uart_flags_pkg::ST_STOP && at_bit)
				rf.char_data <= shift >> align;
		end
	end

	// break watch runs in idle and mid-character alike
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			brk_cnt      <= 9'h000;
			brk_seen     <= 1'b0;
			rf.break_det <= 1'b0;
		end else begin
			rf.break_det <= 1'b0;
			if (!rf.break_en || rf.rxd) begin
				brk_cnt  <= 9'h000;
				brk_seen <= 1'b0;
			end else if (rf.tick && !brk_seen) begin
				brk_cnt <= brk_cnt + 9'h001;
				if (brk_cnt == brk_limit) begin
					brk_seen     <= 1'b1;
					rf.break_det <= 1'b1;
				end
			end
		end
	end

endmodule

// *** tb/uart_status_sva.sv ***
// port assertions for the frame length and status block
`timescale 1ns/1ps
module uart_status_sva (
	// clock and reset
	input logic        clk_i,
	input logic        sys_rst_i,
	// apb slave
	input logic        psel_i,
	input logic        penable_i,
	input logic        pwrite_i,
	input logic [31:0] paddr_i,
	input logic [31:0] pwdata_i,
	input logic [31:0] prdata_o,
	input logic        pready_o,
	input logic        pslverr_o,
	// dma and frame settings
	input logic        rx_dma_ack_i,
	input logic        rx_dma_page_i,
	input logic        tx_dma_page_i,
	input logic        rx_dma_req_o,
	input logic        rx_dma_stop_o,
	input logic        tx_dma_stop_o,
	input logic [3:0]  tx_frame_bits_o,
	input logic        two_stop_o,
	input logic        irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	logic       done_len;
	logic       done_stat;
	logic       exp_stop;
	logic [3:0] exp_tx;
	logic [3:0] next_tx;
	assign done_len  = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 32'h2C000518;
	assign done_stat = psel_i && penable_i && pready_o && pwrite_i && paddr_i == 32'h2C000520;
	// reserved transmit codes are reported as the shortest frame
	assign next_tx = (pwdata_i[3:0] >= 4'h9 && pwdata_i[3:0] <= 4'hC) ? pwdata_i[3:0] : 4'h9;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exp_stop <= 1'h0;
			exp_tx   <= 4'h9;
		end else if (done_len) begin
			exp_stop <= pwdata_i[8];
			exp_tx   <= next_tx;
		end
	end
	a_ready_wait: assert property ($rose(penable_i) && psel_i |=> pready_o)
		else $error("ready missing after one wait state");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
		else $error("slave error outside an access");
	a_read_upper: assert property (pready_o && !pwrite_i |-> prdata_o[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_len_apply: assert property (done_len |->
		##2 two_stop_o == exp_stop && tx_frame_bits_o == exp_tx)
		else $error("frame settings do not follow the length write");
	a_tx_range: assert property (tx_frame_bits_o != 4'h0 |->
		tx_frame_bits_o inside {[4'h9:4'hC]})
		else $error("transmit length outside nine to twelve");
	a_stop_blocks: assert property (rx_dma_stop_o && $past(rx_dma_stop_o) |-> !rx_dma_req_o)
		else $error("request while receive page two stop");
	a_stop_irq: assert property ((rx_dma_stop_o || tx_dma_stop_o) &&
		$past(rx_dma_stop_o || tx_dma_stop_o) |-> irq_o)
		else $error("page two set without interrupt");
	a_page_irq: assert property (rx_dma_page_i || tx_dma_page_i |-> ##[1:3] irq_o)
		else $error("page signal raised no interrupt");
	a_ack_drops: assert property (rx_dma_ack_i && rx_dma_req_o |-> ##[1:2] !rx_dma_req_o)
		else $error("request stays after acknowledge");
	a_irq_clear: assert property ($fell(irq_o) |->
		$past(done_stat) || $past(done_stat, 2))
		else $error("interrupt fell without a status write");
	c_len_write: cover property (done_len);
	c_both_stops: cover property (rx_dma_stop_o && tx_dma_stop_o);
	c_bad_addr: cover property (pslverr_o);
endmodule

// *** tb/serial_peer.sv ***
// serial peer model: receive line, baud tick and modem status lines
`timescale 1ns/1ps
module serial_peer (
	// clock
	input  wire logic clk_i,
	// towards the serial unit
	output logic      rxd_o,
	output logic      tick_o,
	output logic      carrier_o,
	output logic      dsr_o,
	output logic      cts_o
);
	logic [1:0] div;
	initial begin
		div       = 2'h0;
		rxd_o     = 1'h1;
		tick_o    = 1'h0;
		{carrier_o, dsr_o, cts_o} = 3'h0;
	end
	// a tick every fourth clock keeps one bit at 64 clocks
	always @(posedge clk_i) begin
		div    <= div + 2'h1;
		tick_o <= div == 2'h3;
	end
	// first bit first, 16 ticks each; the line rests at mark level afterwards
	task automatic send(input logic [19:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			rxd_o <= b[i];
			// tick is read before its own update at the edge, as the receiver sees it
			repeat (16) begin
				do begin
					@(posedge clk_i);
				end while (!tick_o);
			end
		end
		rxd_o <= 1'h1;
	endtask
	task automatic modem(input logic [2:0] m);
		{carrier_o, dsr_o, cts_o} <= m;
	endtask
endmodule

// *** tb/uart_frame_len_int_status_tb_top.sv ***
// self-checking bench for the frame length and status block
`timescale 1ns/1ps
module uart_frame_len_int_status_tb_top;
	localparam logic [31:0] A_LEN  = 32'h2C000518;
	localparam logic [31:0] A_STAT = 32'h2C000520;
	localparam logic [31:0] A_CTRL = 32'h2C000540;
	localparam logic [31:0] ALL    = 32'hFFFFFFFF;
	logic        clk_i = 1'h0;
	logic        sys_rst_i = 1'h1;
	logic        psel_i = 1'h0;
	logic        penable_i = 1'h0;
	logic        pwrite_i = 1'h0;
	logic [31:0] paddr_i = 32'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic        rx_dma_ack_i = 1'h0;
	logic        rx_dma_page_i = 1'h0;
	logic        tx_dma_page_i = 1'h0;
	logic [31:0] prdata_o;
	logic        pready_o, pslverr_o, rx_dma_req_o, rx_dma_stop_o, tx_dma_stop_o, two_stop_o;
	logic        irq_o, rxd_i, baud16_tick_i, carrier_i, data_set_ready_i, clear_to_send_i;
	logic [8:0]  rx_data_o;
	logic [3:0]  tx_frame_bits_o;
	logic [31:0] rdata;
	logic        serr;
	int          n_errors = 0;
	int          n_compared = 0;

	uart_frame_len_int_status DUT (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rxd_i, .baud16_tick_i,
		.carrier_i, .data_set_ready_i, .clear_to_send_i, .rx_dma_ack_i, .rx_dma_page_i,
		.tx_dma_page_i, .rx_dma_req_o, .rx_dma_stop_o, .tx_dma_stop_o, .rx_data_o,
		.tx_frame_bits_o, .two_stop_o, .irq_o);
	serial_peer peer (.clk_i, .rxd_o(rxd_i), .tick_o(baud16_tick_i), .carrier_o(carrier_i),
		.dsr_o(data_set_ready_i), .cts_o(clear_to_send_i));

	initial forever #2 clk_i = ~clk_i;

	task automatic finish_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// the request is held until ready is seen high at a rising edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel_i   <= 1'h1;
		pwrite_i <= w;
		paddr_i  <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'h1 && n < 40);
		if (n >= 40) begin
			n_errors++;
			finish_test();
		end
		rdata = prdata_o;
		serr  = pslverr_o;
		psel_i    <= 1'h0;
		penable_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rdata & m, e);
	endtask
	task automatic wait_req;
		int n;
		n = 0;
		while (rx_dma_req_o !== 1'h1 && n < 3000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 3000) begin
			n_errors++;
			finish_test();
		end
		repeat (4) @(posedge clk_i);
	endtask
	// 0 acknowledge, 1 receive page, 2 transmit page
	task automatic pulse(input int k);
		if (k == 0) rx_dma_ack_i <= 1'h1;
		if (k == 1) rx_dma_page_i <= 1'h1;
		if (k == 2) tx_dma_page_i <= 1'h1;
		@(posedge clk_i);
		{rx_dma_ack_i, rx_dma_page_i, tx_dma_page_i} <= 3'h0;
		repeat (4) @(posedge clk_i);
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		@(posedge clk_i);
		rd(A_LEN, ALL, 32'h0);
		rd(A_STAT, ALL, 32'h0);
		wr(A_LEN, 32'hFFFF);
		rd(A_LEN, ALL, 32'h1FF);
		wr(A_STAT, 32'hFFFF);
		rd(A_STAT, ALL, 32'h0);
		rd(32'h2C000600, ALL, 32'h0);
		chk(32'(serr), 32'h1);
		for (int c = 9; c <= 12; c++) begin
			wr(A_LEN, 32'h80 | 32'(c) | (32'(c & 1) << 8));
			repeat (2) @(posedge clk_i);
			chk(32'(tx_frame_bits_o), 32'(c));
			chk(32'(two_stop_o), 32'(c & 1));
		end
		wr(A_LEN, 32'h89);
		wr(A_CTRL, 32'h44);
		peer.send(20'h1AA, 9);
		wait_req();
		chk(32'(rx_data_o), 32'h55);
		peer.send(20'h166, 9);
		repeat (4) @(posedge clk_i);
		rd(A_STAT, ALL, 32'h20);
		chk(32'(rx_data_o), 32'h55);
		wr(A_STAT, 32'h0);
		pulse(0);
		chk(32'(rx_dma_req_o), 32'h0);
		rd(A_STAT, ALL, 32'h30);
		chk(32'(irq_o), 32'h1);
		wr(A_STAT, 32'h10);
		rd(A_STAT, ALL, 32'h20);
		wr(A_STAT, 32'h20);
		repeat (2) @(posedge clk_i);
		chk(32'(irq_o), 32'h0);
		// stop bit low: the zero starts the next character straight away
		fork
			peer.send(20'h166AA, 17);
		join_none
		wait_req();
		chk(32'(rx_data_o), 32'h55);
		pulse(0);
		wait_req();
		chk(32'(rx_data_o), 32'h33);
		rd(A_STAT, 32'h200, 32'h200);
		repeat (64) @(posedge clk_i);
		pulse(0);
		wr(A_LEN, 32'h99);
		peer.send(20'h34A, 10);
		wait_req();
		chk(32'(rx_data_o), 32'hA5);
		pulse(0);
		wr(A_STAT, 32'h7FF);
		wr(A_LEN, 32'h1A9);
		peer.send(20'hF4A, 12);
		wait_req();
		chk(32'(rx_data_o), 32'h1A5);
		rd(A_STAT, ALL, 32'h0);
		pulse(0);
		peer.send(20'h74A, 12);
		repeat (4) @(posedge clk_i);
		rd(A_STAT, 32'h200, 32'h200);
		wr(A_LEN, 32'h89);
		peer.send(20'h0, 12);
		repeat (4) @(posedge clk_i);
		rd(A_STAT, 32'h400, 32'h400);
		wr(A_CTRL, 32'h4);
		wr(A_STAT, 32'h7FF);
		peer.send(20'h0, 12);
		repeat (4) @(posedge clk_i);
		rd(A_STAT, 32'h400, 32'h0);
		peer.modem(3'h7);
		repeat (8) @(posedge clk_i);
		rd(A_STAT, 32'h1C0, 32'h0);
		wr(A_CTRL, 32'h44);
		peer.modem(3'h0);
		repeat (8) @(posedge clk_i);
		rd(A_STAT, 32'h1C0, 32'h1C0);
		wr(A_STAT, 32'h1C0);
		rd(A_STAT, 32'h1C0, 32'h0);
		peer.modem(3'h7);
		repeat (8) @(posedge clk_i);
		rd(A_STAT, 32'h1C0, 32'h1C0);
		repeat (800) @(posedge clk_i);
		pulse(0);
		wr(A_STAT, 32'h7FF);
		pulse(1);
		rd(A_STAT, 32'hF, 32'h4);
		pulse(1);
		rd(A_STAT, 32'hF, 32'hC);
		chk(32'(rx_dma_stop_o), 32'h1);
		peer.send(20'h1AA, 9);
		repeat (4) @(posedge clk_i);
		chk(32'(rx_dma_req_o), 32'h0);
		pulse(2);
		pulse(2);
		rd(A_STAT, 32'hF, 32'hF);
		chk(32'(tx_dma_stop_o), 32'h1);
		wr(A_STAT, 32'h7FF);
		repeat (2) @(posedge clk_i);
		chk(32'(irq_o), 32'h0);
		chk(32'(rx_dma_stop_o | tx_dma_stop_o), 32'h0);
		finish_test();
	end
endmodule

bind uart_frame_len_int_status uart_status_sva u_sva (.clk_i, .sys_rst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_dma_ack_i,
	.rx_dma_page_i, .tx_dma_page_i, .rx_dma_req_o, .rx_dma_stop_o, .tx_dma_stop_o,
	.tx_frame_bits_o, .two_stop_o, .irq_o);
